// ==== cnsf_regs.sv ====
// Charger thermistor settings, live status and latched event flags behind the serial register port.
// Assumes the serial slave presents one-cycle read and write strobes and the
// condition inputs are already synchronous to i_clk.
//
// Behaviour
// - Bits 7:5 pick cold thresholds, reset 001b.
// - Bits 4:2 pick hot thresholds, reset 001b.
// - Warm zone cuts voltage by warm field.
// - Mirror bit reuses warm cuts for cool.
// - Prewarm zone cuts voltage, reset unchanged.
// - Prewarm zone scales current, reset unchanged.
// - Precool zone scales current, reset unchanged.
// - Conversion done status only in one-shot.
// - Live regulation status bits five to two.
// - Timer and watchdog expiry live status.
// - Charge phase code in bits 4:3.
// - Input source code in bits 2:0.
// - Fault bit 7 for input stop.
// - Fault bits 6, 5 battery and rail.
// - Fault bit 3 for thermal shutdown.
// - Thermistor zone code in bits 2:0.
// - Conversion flag latches only in one-shot.
// - Flags 5,3,2 latch on rising edges.
// - Flag 4 latches on entry and exit.
// - Flags 1,0 latch on expiry edges.
// - Second flags latch phase, source changes.
// - Unmasked events pulse the interrupt output.
`timescale 1ns/1ps
`include "cnsf_cfg.svh"

module cnsf_regs (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  // Register port
  input  cnsf_pkg::cnsf_req_s        i_req,
  output logic [7:0]                 o_rdata,
  output logic                       o_rvalid,
  // Live conditions
  input  cnsf_pkg::cnsf_cond_s       i_cond,
  // Outputs to the charger
  output logic [2:0]                 o_cold_side_threshold_select,
  output logic [2:0]                 o_hot_side_threshold_select,
  output cnsf_pkg::cnsf_adjust_s     o_adjust,
  output logic                       o_int_pulse
);
  import cnsf_pkg::*;

  typedef struct packed {
    logic [7:0] thr_warm;
    logic [7:0] mid_zone;
    logic [7:0] mask0;
    logic [7:0] mask1;
    logic [7:0] flags0;
    logic [7:0] flags1;
    cnsf_cond_s cond_prev;
    logic [7:0] rdata;
    logic       rvalid;
    logic       irq;
  } cnsf_state_s;

  cnsf_state_s state_q;
  cnsf_state_s state_d;

  logic [7:0] live_stat;
  logic [7:0] phase_src;
  logic [7:0] fault_stat;
  logic [7:0] ev0;
  logic [7:0] ev1;
  logic [7:0] rd_val;

  ////////////////////////////////////////////////////////////////////////////////
  // Live status views.

  always_comb begin
    live_stat    = 8'h00;
    live_stat[6] = i_cond.conversion_done & i_cond.one_shot_mode;
    live_stat[5] = i_cond.die_thermal_reg;
    live_stat[4] = i_cond.min_sys_voltage_reg;
    live_stat[3] = i_cond.input_current_reg;
    live_stat[2] = i_cond.input_voltage_reg;
    live_stat[1] = i_cond.charge_timer_expired;
    live_stat[0] = i_cond.watchdog_expired;
  end

  always_comb begin
    phase_src      = 8'h00;
    phase_src[4:3] = i_cond.charge_phase_code;
    phase_src[2:0] = i_cond.input_source_code;
  end

  always_comb begin
    fault_stat      = 8'h00;
    fault_stat[7]   = i_cond.input_fault;
    fault_stat[6]   = i_cond.battery_fault;
    fault_stat[5]   = i_cond.system_rail_fault;
    fault_stat[3]   = i_cond.thermal_shutdown;
    fault_stat[2:0] = i_cond.thermistor_zone_code;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event detection against the previous cycle's conditions.

  always_comb begin
    ev0    = 8'h00;
    ev0[6] = i_cond.one_shot_mode & i_cond.conversion_done
           & ~state_q.cond_prev.conversion_done;
    ev0[5] = i_cond.die_thermal_reg & ~state_q.cond_prev.die_thermal_reg;
    ev0[4] = i_cond.min_sys_voltage_reg ^ state_q.cond_prev.min_sys_voltage_reg;
    ev0[3] = i_cond.input_current_reg & ~state_q.cond_prev.input_current_reg;
    ev0[2] = i_cond.input_voltage_reg & ~state_q.cond_prev.input_voltage_reg;
    ev0[1] = i_cond.charge_timer_expired & ~state_q.cond_prev.charge_timer_expired;
    ev0[0] = i_cond.watchdog_expired & ~state_q.cond_prev.watchdog_expired;
  end

  always_comb begin
    ev1    = 8'h00;
    ev1[3] = (i_cond.charge_phase_code != state_q.cond_prev.charge_phase_code);
    ev1[0] = (i_cond.input_source_code != state_q.cond_prev.input_source_code);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped offsets read as zero.

  always_comb begin
    rd_val = 8'h00;
    if (i_req.addr == `CNSF_OFS_THR_WARM) begin
      rd_val = state_q.thr_warm;
    end else if (i_req.addr == `CNSF_OFS_MID_ZONE) begin
      rd_val = state_q.mid_zone;
    end else if (i_req.addr == `CNSF_OFS_LIVE_STAT) begin
      rd_val = live_stat;
    end else if (i_req.addr == `CNSF_OFS_PHASE_SRC) begin
      rd_val = phase_src;
    end else if (i_req.addr == `CNSF_OFS_FAULT_STAT) begin
      rd_val = fault_stat;
    end else if (i_req.addr == `CNSF_OFS_FLAGS0) begin
      rd_val = state_q.flags0;
    end else if (i_req.addr == `CNSF_OFS_FLAGS1) begin
      rd_val = state_q.flags1;
    end else if (i_req.addr == `CNSF_OFS_MASK0) begin
      rd_val = state_q.mask0;
    end else if (i_req.addr == `CNSF_OFS_MASK1) begin
      rd_val = state_q.mask1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    state_d           = state_q;
    state_d.cond_prev = i_cond;
    state_d.rvalid    = i_req.rd;
    if (i_req.rd) begin
      state_d.rdata = rd_val;
    end
    // A read clears only the bits it returned; a new event in the same cycle survives.
    if (i_req.rd && (i_req.addr == `CNSF_OFS_FLAGS0)) begin
      state_d.flags0 = 8'h00;
    end
    if (i_req.rd && (i_req.addr == `CNSF_OFS_FLAGS1)) begin
      state_d.flags1 = 8'h00;
    end
    state_d.flags0 = state_d.flags0 | ev0;
    state_d.flags1 = state_d.flags1 | (ev1 & `CNSF_FLAGS1_MASK);
    if (i_req.wr) begin
      if (i_req.addr == `CNSF_OFS_THR_WARM) begin
        state_d.thr_warm = i_req.wdata;
      end else if (i_req.addr == `CNSF_OFS_MID_ZONE) begin
        state_d.mid_zone = i_req.wdata & `CNSF_MID_ZONE_RW_MASK;
      end else if (i_req.addr == `CNSF_OFS_MASK0) begin
        state_d.mask0 = i_req.wdata & 8'h7F;
      end else if (i_req.addr == `CNSF_OFS_MASK1) begin
        state_d.mask1 = i_req.wdata & `CNSF_FLAGS1_MASK;
      end
    end
    state_d.irq = |(ev0 & ~state_q.mask0) | |(ev1 & `CNSF_FLAGS1_MASK & ~state_q.mask1);
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q.thr_warm  <= `CNSF_RST_THR_WARM;
      state_q.mid_zone  <= `CNSF_RST_MID_ZONE;
      state_q.mask0     <= `CNSF_RST_MASK;
      state_q.mask1     <= `CNSF_RST_MASK;
      state_q.flags0    <= 8'h00;
      state_q.flags1    <= 8'h00;
      state_q.cond_prev <= '0;
      state_q.rdata     <= 8'h00;
      state_q.rvalid    <= 1'b0;
      state_q.irq       <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Zone adjustment and outputs.

  cnsf_zone_adjust u_zone_adjust (
    .i_clk                        (i_clk),
    .i_reset_n                    (i_reset_n),
    .i_zone                       (i_cond.thermistor_zone_code),
    .i_warm_zone_voltage_cut      (state_q.thr_warm[1:0]),
    .i_cool_mirror_warm_enable    (state_q.mid_zone[6]),
    .i_prewarm_zone_voltage_cut   (state_q.mid_zone[5:4]),
    .i_prewarm_zone_current_scale (state_q.mid_zone[3:2]),
    .i_precool_zone_current_scale (state_q.mid_zone[1:0]),
    .o_adjust                     (o_adjust)
  );

  assign o_cold_side_threshold_select = state_q.thr_warm[7:5];
  assign o_hot_side_threshold_select  = state_q.thr_warm[4:2];
  assign o_rdata                      = state_q.rdata;
  assign o_rvalid                     = state_q.rvalid;
  assign o_int_pulse                  = state_q.irq;

endmodule : cnsf_regs

// ==== cnsf_cfg.svh ====
// Register offsets, field positions, reset values and code points of the charger register bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CNSF_CFG_SVH
`define CNSF_CFG_SVH

`define CNSF_OFS_THR_WARM      8'h1B
`define CNSF_OFS_MID_ZONE      8'h1C
`define CNSF_OFS_LIVE_STAT     8'h1D
`define CNSF_OFS_PHASE_SRC     8'h1E
`define CNSF_OFS_FAULT_STAT    8'h1F
`define CNSF_OFS_FLAGS0        8'h20
`define CNSF_OFS_FLAGS1        8'h21
`define CNSF_OFS_MASK0         8'h23
`define CNSF_OFS_MASK1         8'h24

`define CNSF_RST_THR_WARM      8'h25
`define CNSF_RST_MID_ZONE      8'h3F
`define CNSF_RST_MASK          8'h00

`define CNSF_MID_ZONE_RW_MASK  8'h7F
`define CNSF_FLAGS1_MASK       8'h09
`define CNSF_SRC_OFF           3'h0
`define CNSF_SRC_UNKNOWN       3'h4

`define CNSF_VCUT_300          2'h0
`define CNSF_VCUT_200          2'h1
`define CNSF_VCUT_100          2'h2
`define CNSF_ISCALE_SUSPEND    2'h0
`define CNSF_ISCALE_20         2'h1
`define CNSF_ISCALE_40         2'h2

`define CNSF_ZONE_NORMAL       3'h0
`define CNSF_ZONE_COLD         3'h1
`define CNSF_ZONE_HOT          3'h2
`define CNSF_ZONE_COOL         3'h3
`define CNSF_ZONE_WARM         3'h4
`define CNSF_ZONE_PRECOOL      3'h5
`define CNSF_ZONE_PREWARM      3'h6
`define CNSF_ZONE_BIAS_FAULT   3'h7

`endif

// ==== cnsf_pkg.sv ====
// Types shared by the charger register bank and its zone adjust module.
// Assumes the constants header sits in the same folder.
`include "cnsf_cfg.svh"

package cnsf_pkg;

  // Live conditions from the analog and timer blocks, already in the clock domain.
  typedef struct packed {
    logic       one_shot_mode;
    logic       conversion_done;
    logic       die_thermal_reg;
    logic       min_sys_voltage_reg;
    logic       input_current_reg;
    logic       input_voltage_reg;
    logic       charge_timer_expired;
    logic       watchdog_expired;
    logic [1:0] charge_phase_code;
    logic [2:0] input_source_code;
    logic       input_fault;
    logic       battery_fault;
    logic       system_rail_fault;
    logic       thermal_shutdown;
    logic [2:0] thermistor_zone_code;
  } cnsf_cond_s;

  // Zone adjustment handed to the regulation loops.
  typedef struct packed {
    logic       suspend;
    logic [8:0] voltage_cut_mv;
    logic [6:0] current_percent;
  } cnsf_adjust_s;

  // Register bus request as presented by the serial slave.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cnsf_req_s;

endpackage : cnsf_pkg

// ==== cnsf_zone_adjust.sv ====
// Maps the thermistor zone and the zone settings to a voltage cut and a current scale.
// Assumes zone code and settings come from the register bank on the same clock.
`timescale 1ns/1ps
`include "cnsf_cfg.svh"

module cnsf_zone_adjust (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  // Zone and settings
  input  wire logic [2:0]            i_zone,
  input  wire logic [1:0]            i_warm_zone_voltage_cut,
  input  wire logic                  i_cool_mirror_warm_enable,
  input  wire logic [1:0]            i_prewarm_zone_voltage_cut,
  input  wire logic [1:0]            i_prewarm_zone_current_scale,
  input  wire logic [1:0]            i_precool_zone_current_scale,
  // Adjustment
  output cnsf_pkg::cnsf_adjust_s     o_adjust
);
  import cnsf_pkg::*;

  typedef struct packed {
    cnsf_adjust_s adj;
  } cnsf_za_state_s;

  cnsf_za_state_s state_q;
  cnsf_za_state_s state_d;

  function automatic logic [8:0] vcut(input logic [1:0] code);
    logic [8:0] mv;
    mv = 9'h000;
    if (code == `CNSF_VCUT_300) begin
      mv = 9'h12C;
    end else if (code == `CNSF_VCUT_200) begin
      mv = 9'h0C8;
    end else if (code == `CNSF_VCUT_100) begin
      mv = 9'h064;
    end
    return mv;
  endfunction : vcut

  function automatic logic [6:0] iscale(input logic [1:0] code);
    logic [6:0] pct;
    pct = 7'h64;
    if (code == `CNSF_ISCALE_SUSPEND) begin
      pct = 7'h00;
    end else if (code == `CNSF_ISCALE_20) begin
      pct = 7'h14;
    end else if (code == `CNSF_ISCALE_40) begin
      pct = 7'h28;
    end
    return pct;
  endfunction : iscale

  always_comb begin
    state_d                     = state_q;
    state_d.adj.voltage_cut_mv  = 9'h000;
    state_d.adj.current_percent = 7'h64;
    case (i_zone)
      `CNSF_ZONE_WARM: begin
        state_d.adj.voltage_cut_mv = vcut(i_warm_zone_voltage_cut);
      end
      `CNSF_ZONE_PREWARM: begin
        state_d.adj.voltage_cut_mv  = vcut(i_prewarm_zone_voltage_cut);
        state_d.adj.current_percent = iscale(i_prewarm_zone_current_scale);
      end
      `CNSF_ZONE_COOL: begin
        if (i_cool_mirror_warm_enable) begin
          state_d.adj.voltage_cut_mv = vcut(i_warm_zone_voltage_cut);
        end
      end
      `CNSF_ZONE_PRECOOL: begin
        if (i_cool_mirror_warm_enable) begin
          state_d.adj.voltage_cut_mv = vcut(i_prewarm_zone_voltage_cut);
        end
        state_d.adj.current_percent = iscale(i_precool_zone_current_scale);
      end
      default: begin
      end
    endcase
    state_d.adj.suspend = (state_d.adj.current_percent == 7'h00);
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= '{adj: '{suspend: 1'b0, voltage_cut_mv: 9'h000, current_percent: 7'h64}};
    end else begin
      state_q <= state_d;
    end
  end

  assign o_adjust = state_q.adj;

endmodule : cnsf_zone_adjust

// ==== cnsf_host_model.sv ====
// Host side of the register port, one request at a time from the falling edge.
// Assumes the bank answers a read at the rising edge after the strobe.
`timescale 1ns/1ps
module cnsf_host_model (
  // Clock
  input  wire logic           i_clk,
  // Register port
  output cnsf_pkg::cnsf_req_s o_req,
  input  wire logic [7:0]     i_rdata,
  input  wire logic           i_rvalid
);
  import cnsf_pkg::*;
  initial o_req = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // Released lines show the inverse so a stale value never looks valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_req <= '{1'b1, 1'b0, a, d};
    @(negedge i_clk);
    o_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge i_clk);
    o_req <= '{1'b0, 1'b0, ~a, 8'hFF};
    d = i_rdata;
    v = i_rvalid;
  endtask : rd
endmodule : cnsf_host_model

// ==== cnsf_regs_asserts.sv ====
// Assertions on the ports of the charger register bank.
// Assumes the bind at the foot attaches it to every cnsf_regs.
`timescale 1ns/1ps
module cnsf_regs_check (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // Register port
  input  cnsf_pkg::cnsf_req_s    i_req,
  input  wire logic [7:0]        o_rdata,
  input  wire logic              o_rvalid,
  // Conditions and outputs
  input  cnsf_pkg::cnsf_cond_s   i_cond,
  input  wire logic [2:0]        o_cold_side_threshold_select,
  input  wire logic [2:0]        o_hot_side_threshold_select,
  input  cnsf_pkg::cnsf_adjust_s o_adjust,
  input  wire logic              o_int_pulse
);
  import cnsf_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  logic rd20;
  assign rd20 = i_req.rd && i_req.addr == 8'h20;
  logic rd21;
  assign rd21 = i_req.rd && i_req.addr == 8'h21;
  sequence s_rd(logic [7:0] a);
    i_req.rd && i_req.addr == a;
  endsequence
  // The idle cycle keeps an earlier read from clearing the flag under test.
  sequence s_gap;
    !rd20 ##1 rd20;
  endsequence
  sequence s_gap21;
    !rd21 ##1 rd21;
  endsequence
  property p_answer;
    i_req.rd |=> o_rvalid;
  endproperty
  property p_done_stat;
    s_rd(8'h1D) |=> o_rdata[6] == $past(i_cond.one_shot_mode & i_cond.conversion_done);
  endproperty
  // Packed order puts the six live levels in bits 17:12.
  property p_live_stat;
    s_rd(8'h1D) |=> o_rdata[5:0] == $past(i_cond[17:12]);
  endproperty
  property p_phase_src;
    s_rd(8'h1E) |=> o_rdata == {3'h0, $past(i_cond[11:7])};
  endproperty
  property p_fault;
    s_rd(8'h1F) |=> o_rdata == {$past(i_cond[6:4]), 1'b0, $past(i_cond[3:0])};
  endproperty
  property p_select;
    i_req.wr && i_req.addr == 8'h1B |=>
      {o_cold_side_threshold_select, o_hot_side_threshold_select} == $past(i_req.wdata[7:2]);
  endproperty
  property p_rise_flag;
    $rose(i_cond.die_thermal_reg) ##1 s_gap |=> o_rdata[5];
  endproperty
  property p_sys_flag;
    $changed(i_cond.min_sys_voltage_reg) ##1 s_gap |=> o_rdata[4];
  endproperty
  property p_clear;
    rd20 && $stable(i_cond) ##1 $stable(i_cond) ##1 rd20 && $stable(i_cond) |=> o_rdata == 8'h00;
  endproperty
  property p_phase_flag;
    $changed(i_cond.charge_phase_code) ##1 rd21 |=> o_rdata[3];
  endproperty
  property p_src_flag;
    $changed(i_cond.input_source_code) ##1 s_gap21 |=> o_rdata[0];
  endproperty
  // The previous-condition copy is zero after reset, so the first two cycles are left out.
  property p_int_cause;
    o_int_pulse && $past(i_reset_n, 2) |-> $past(i_cond) != $past(i_cond, 2);
  endproperty
  a_answer: assert property (p_answer) else $error("read got no answer");
  a_done_stat: assert property (p_done_stat) else $error("conversion status wrong");
  a_live_stat: assert property (p_live_stat) else $error("live status wrong");
  a_phase_src: assert property (p_phase_src) else $error("phase or source wrong");
  a_fault: assert property (p_fault) else $error("fault status wrong");
  a_select: assert property (p_select) else $error("threshold select wrong");
  a_rise_flag: assert property (p_rise_flag) else $error("rising edge flag lost");
  a_sys_flag: assert property (p_sys_flag) else $error("regulation change flag lost");
  a_clear: assert property (p_clear) else $error("flags not cleared by read");
  a_phase_flag: assert property (p_phase_flag) else $error("phase change flag lost");
  a_src_flag: assert property (p_src_flag) else $error("source change flag lost");
  a_int_cause: assert property (p_int_cause) else $error("pulse without event");
endmodule : cnsf_regs_check

bind cnsf_regs cnsf_regs_check u_check (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req), .o_rdata(o_rdata),
  .o_rvalid(o_rvalid), .i_cond(i_cond), .o_adjust(o_adjust), .o_int_pulse(o_int_pulse),
  .o_cold_side_threshold_select(o_cold_side_threshold_select),
  .o_hot_side_threshold_select(o_hot_side_threshold_select)
);

// ==== testbench.sv ====
// Self-checking bench for the charger register bank with a host model on its port.
// Assumes the package, design, host model and checker are compiled first.
`timescale 1ns/1ps
`include "cnsf_cfg.svh"
module testbench;
  import cnsf_pkg::*;
  logic         i_clk = 1'b0;
  logic         i_reset_n = 1'b0;
  cnsf_req_s    req;
  cnsf_cond_s   cond = '0;
  cnsf_adjust_s adj;
  logic [7:0]   rdata, d, r1b, r1c;
  logic         rvalid, v, intp;
  logic [2:0]   cold, hot;
  int           n_fail = 0;
  int           check_count = 0;
  always #2.5 i_clk = ~i_clk;
  cnsf_regs dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_cond(cond), .o_cold_side_threshold_select(cold),
    .o_hot_side_threshold_select(hot), .o_adjust(adj), .o_int_pulse(intp));
  cnsf_host_model host (.i_clk(i_clk), .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [16:0] e, input logic [16:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d, v);
    chk(17'(e), 17'(d));
    chk(17'h1, 17'(v));
  endtask : rchk
  function automatic logic [8:0] f_cut(input logic [1:0] c);
    return (c == 2'h3) ? 9'h000 : 9'(300 - 100 * c);
  endfunction : f_cut
  function automatic logic [6:0] f_pct(input logic [1:0] c);
    return (c == 2'h3) ? 7'h64 : 7'(20 * c);
  endfunction : f_pct
  function automatic cnsf_adjust_s f_adj(input logic [2:0] z);
    logic [8:0] c;
    logic [6:0] p;
    c = 9'h000;
    p = 7'h64;
    case (z)
      `CNSF_ZONE_WARM: c = f_cut(r1b[1:0]);
      `CNSF_ZONE_COOL: c = r1c[6] ? f_cut(r1b[1:0]) : 9'h000;
      `CNSF_ZONE_PREWARM: begin
        c = f_cut(r1c[5:4]);
        p = f_pct(r1c[3:2]);
      end
      `CNSF_ZONE_PRECOOL: begin
        c = r1c[6] ? f_cut(r1c[5:4]) : 9'h000;
        p = f_pct(r1c[1:0]);
      end
      default: ;
    endcase
    return '{p == 7'h00, c, p};
  endfunction : f_adj
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (40000) @(posedge i_clk);
    n_fail++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hAE84));
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_reset_n = 1'b1;
    chk(17'h9, {11'h0, cold, hot});
    chk(17'h64, adj);
    rchk(8'h1B, 8'h25);
    rchk(8'h1C, 8'h3F);
    for (int a = 8'h1D; a <= 8'h21; a++) rchk(8'(a), 8'h00);
    rchk(8'h30, 8'h00);
    $display("test 1 done");
    // Settings drawn at random, zones stepped in turn, every zone met three times.
    for (int i = 0; i < 24; i++) begin
      r1b = 8'($urandom);
      r1c = 8'($urandom);
      host.wr(8'h1B, r1b);
      host.wr(8'h1C, r1c);
      host.wr(8'h1D, 8'hFF);
      r1c[7] = 1'b0;
      cond.thermistor_zone_code = 3'(i);
      repeat (2) @(negedge i_clk);
      chk(f_adj(3'(i)), adj);
      chk({11'h0, r1b[7:2]}, {11'h0, cold, hot});
      rchk(8'h1C, r1c);
      rchk(8'h1F, {5'h0, 3'(i)});
    end
    rchk(8'h1D, 8'h00);
    // A reset in mid-run must bring the written settings back to their defaults.
    @(negedge i_clk);
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_reset_n = 1'b1;
    chk(17'h9, {11'h0, cold, hot});
    rchk(8'h1B, 8'h25);
    rchk(8'h1C, 8'h3F);
    $display("test 2 done");
    for (int i = 0; i < 16; i++) begin
      cond = cnsf_cond_s'(20'($urandom));
      rchk(8'h1D, {1'b0, cond.one_shot_mode & cond.conversion_done, cond[17:12]});
      rchk(8'h1E, {3'h0, cond[11:7]});
      rchk(8'h1F, {cond[6:4], 1'b0, cond[3:0]});
    end
    cond = '0;
    cond.conversion_done = 1'b1;
    rchk(8'h1D, 8'h00);
    $display("test 3 done");
    cond = '0;
    host.rd(8'h20, d, v);
    host.rd(8'h21, d, v);
    rchk(8'h20, 8'h00);
    rchk(8'h21, 8'h00);
    cond[19:12] = 8'hFF;
    @(negedge i_clk);
    chk(17'h1, 17'(intp));
    rchk(8'h20, 8'h7F);
    rchk(8'h20, 8'h00);
    cond[19:12] = 8'h00;
    @(negedge i_clk);
    rchk(8'h20, 8'h10);
    cond.conversion_done = 1'b1;
    rchk(8'h20, 8'h00);
    host.wr(8'h23, 8'h20);
    cond.die_thermal_reg = 1'b1;
    @(negedge i_clk);
    chk(17'h0, 17'(intp));
    rchk(8'h20, 8'h20);
    rchk(8'h23, 8'h20);
    cond.charge_phase_code = 2'h2;
    rchk(8'h21, 8'h08);
    cond.input_source_code = `CNSF_SRC_UNKNOWN;
    @(negedge i_clk);
    chk(17'h1, 17'(intp));
    rchk(8'h21, 8'h01);
    rchk(8'h1E, 8'h14);
    // Second mask register: only its two live bits stick, and a masked change stays silent.
    host.wr(8'h24, 8'hFF);
    rchk(8'h24, 8'h09);
    cond.charge_phase_code = 2'h1;
    @(negedge i_clk);
    chk(17'h0, 17'(intp));
    rchk(8'h21, 8'h08);
    $display("test 4 done");
    end_of_test();
  end
endmodule : testbench
